// File: rtl/lrc_lockout_ctrl.sv
// Lockout, recovery and diagnostic display control for one sensor.
// Assumes inputs synchronous to mclk; sense inputs follow the driven
// outputs within one cycle; rst_b is the power-up reset.
`timescale 1ns/1ps
module lrc_lockout_ctrl
   import lrc_pkg::*;
#(
   parameter bit IS_EMITTER = 1'b0,
   parameter int RST_MIN    = RST_MIN_CYC,
   parameter int RST_MAX    = RST_MAX_CYC,
   parameter int HOLD       = HOLD_CYC,
   parameter int ALT        = ALT_CYC
) (
   input  wire logic       mclk,
   input  wire logic       rst_b,
   input  wire logic       latch_mode,
   input  wire logic       run_ok,
   input  wire logic       reset_in,
   input  wire logic       flip_btn,
   input  wire logic       int_fault,
   input  wire logic [7:0] int_code,
   input  wire logic       ssw1_sense,
   input  wire logic       ssw2_sense,
   input  wire logic       overload,
   input  wire logic [7:0] adv_code_a,
   input  wire logic [7:0] adv_code_b,
   output logic            safety_switch_output1_r,
   output logic            safety_switch_output2_r,
   output logic            lockout_r,
   output logic [1:0]      disp_sel_r,
   output logic [7:0]      disp_data_r
);

   // Refuse timings the counters cannot hold
   if (RST_MIN < 1 || RST_MAX <= RST_MIN || HOLD < 1 || ALT < 1 ||
       RST_MAX >= (1 << CNT_W) || HOLD >= (1 << CNT_W) ||
       ALT >= (1 << CNT_W)) begin : g_bad_timing
      $error("lrc_lockout_ctrl: unusable timing parameters");
   end

   function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
      sat_inc = (&v) ? v : v + 1'b1;
   endfunction : sat_inc

   localparam logic [CNT_W-1:0] MIN_C  = CNT_W'(RST_MIN);
   localparam logic [CNT_W-1:0] MAX_C  = CNT_W'(RST_MAX);
   localparam logic [CNT_W-1:0] HOLD_C = CNT_W'(HOLD);
   localparam logic [CNT_W-1:0] ALT_C  = CNT_W'(ALT - 1);

   lrc_state_type    state_r, state_nxt;
   logic [7:0]       code_r, code_nxt;
   logic [CNT_W-1:0] rcnt_r, fcnt_r, acnt_r;
   logic             rst_d_r, adv_r, phase_r;

   // ----------------------------------------------------------------
   // Fault and reset-pulse decode
   // ----------------------------------------------------------------
   wire drive_on  = safety_switch_output1_r;
   wire out_fault = (ssw1_sense != drive_on) || (ssw2_sense != drive_on) ||
                    (ssw1_sense != ssw2_sense) || overload;
   wire any_fault = int_fault || out_fault;
   wire rst_fall  = rst_d_r && !reset_in;
   wire pulse_ok  = rst_fall && (rcnt_r >= MIN_C) && (rcnt_r <= MAX_C);
   wire reset_ok  = pulse_ok && !IS_EMITTER;
   wire rst_hold5 = reset_in && (rcnt_r == HOLD_C - 1'b1);
   wire flip_hold = flip_btn && (fcnt_r == HOLD_C - 1'b1);
   wire alt_tick  = (acnt_r == ALT_C);

   // ----------------------------------------------------------------
   // State machine
   // ----------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      code_nxt  = code_r;
      case (state_r)
         ST_PWRUP: begin
            if (reset_in && !IS_EMITTER) begin
               state_nxt = ST_LOCK;
               code_nxt  = CODE_RESET;
            end else if (int_fault) begin
               state_nxt = ST_LOCK;
               code_nxt  = int_code;
            end else if (latch_mode && !IS_EMITTER) begin
               state_nxt = ST_WAIT;
            end else begin
               state_nxt = ST_RUN;
            end
         end
         ST_WAIT, ST_RUN: begin
            if (int_fault) begin
               state_nxt = ST_LOCK;
               code_nxt  = int_code;
            end else if (state_r == ST_RUN && out_fault) begin
               state_nxt = ST_LOCK;
               code_nxt  = CODE_OUTPUT;
            end else if (state_r == ST_WAIT && reset_ok) begin
               state_nxt = ST_RUN;
            end
         end
         default: begin
            if (reset_ok && !int_fault) begin
               state_nxt = ST_RUN;
               code_nxt  = CODE_NONE;
            end
         end
      endcase
   end

   wire sso_nxt = (state_nxt == ST_RUN) && run_ok && !any_fault &&
                  !IS_EMITTER;

   // ----------------------------------------------------------------
   // Display selection
   // ----------------------------------------------------------------
   wire lock_nxt = (state_nxt == ST_LOCK);
   wire adv_nxt  = lock_nxt && (adv_r ? !flip_hold : (rst_hold5 || flip_hold));
   wire [1:0] dsel_nxt = !adv_nxt ? DSEL_STD :
                         (phase_r ? DSEL_ADV_B : DSEL_ADV_A);
   wire [7:0] ddat_nxt = !adv_nxt ? (lock_nxt ? code_nxt : CODE_NONE) :
                         (phase_r ? adv_code_b : adv_code_a);

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         state_r <= ST_PWRUP;
         code_r  <= CODE_NONE;
         rst_d_r <= 1'b0;
         rcnt_r  <= '0;
         fcnt_r  <= '0;
         acnt_r  <= '0;
         phase_r <= 1'b0;
         adv_r   <= 1'b0;
      end else begin
         state_r <= state_nxt;
         code_r  <= code_nxt;
         rst_d_r <= reset_in;
         rcnt_r  <= reset_in ? sat_inc(rcnt_r) : '0;
         fcnt_r  <= flip_btn ? sat_inc(fcnt_r) : '0;
         acnt_r  <= alt_tick ? '0 : acnt_r + 1'b1;
         phase_r <= alt_tick ? !phase_r : phase_r;
         adv_r   <= adv_nxt;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         safety_switch_output1_r <= 1'b0;
         safety_switch_output2_r <= 1'b0;
         lockout_r               <= 1'b0;
         disp_sel_r              <= DSEL_STD;
         disp_data_r             <= CODE_NONE;
      end else begin
         safety_switch_output1_r <= sso_nxt;
         safety_switch_output2_r <= sso_nxt;
         lockout_r               <= lock_nxt;
         disp_sel_r              <= dsel_nxt;
         disp_data_r             <= ddat_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   property p_lock_off;
      @(posedge mclk) disable iff (!rst_b)
      lockout_r |-> !safety_switch_output1_r && !safety_switch_output2_r;
   endproperty
   a_lock_off: assert property (p_lock_off)
      else $error("outputs on during lockout");

   property p_code_shown;
      @(posedge mclk) disable iff (!rst_b)
      lockout_r && disp_sel_r == DSEL_STD |-> disp_data_r == code_r;
   endproperty
   a_code_shown: assert property (p_code_shown)
      else $error("lockout code not displayed");

   property p_recover;
      @(posedge mclk) disable iff (!rst_b)
      state_r == ST_LOCK && reset_ok && !int_fault |=>
         state_r == ST_RUN && !lockout_r;
   endproperty
   a_recover: assert property (p_recover)
      else $error("valid reset did not clear lockout");

   property p_short_pulse;
      @(posedge mclk) disable iff (!rst_b)
      state_r == ST_LOCK && rst_fall && rcnt_r < MIN_C |=> lockout_r;
   endproperty
   a_short_pulse: assert property (p_short_pulse)
      else $error("short reset pulse cleared lockout");

   property p_window;
      @(posedge mclk) disable iff (!rst_b)
      state_r == ST_LOCK && rst_fall && rcnt_r == MIN_C && !int_fault &&
      !IS_EMITTER |=> !lockout_r;
   endproperty
   a_window: assert property (p_window)
      else $error("minimum reset pulse refused");

   property p_latch_pwrup;
      @(posedge mclk) disable iff (!rst_b)
      state_r == ST_PWRUP && latch_mode && !reset_in && !int_fault &&
      !IS_EMITTER |=> state_r == ST_WAIT ##1 !safety_switch_output1_r;
   endproperty
   a_latch_pwrup: assert property (p_latch_pwrup)
      else $error("latch mode ran without manual reset");

   property p_emitter;
      @(posedge mclk) disable iff (!rst_b)
      IS_EMITTER && state_r == ST_LOCK |=> state_r == ST_LOCK;
   endproperty
   a_emitter: assert property (p_emitter)
      else $error("emitter left lockout without power cycle");

   property p_adv_on;
      @(posedge mclk) disable iff (!rst_b)
      state_r == ST_LOCK && !adv_r && rst_hold5 && lock_nxt |=>
         disp_sel_r != DSEL_STD;
   endproperty
   a_adv_on: assert property (p_adv_on)
      else $error("advanced codes not shown");

   property p_adv_off;
      @(posedge mclk) disable iff (!rst_b)
      adv_r && flip_hold |=> disp_sel_r == DSEL_STD;
   endproperty
   a_adv_off: assert property (p_adv_off)
      else $error("flip hold did not restore standard display");

   property p_out_fault;
      @(posedge mclk) disable iff (!rst_b)
      state_r == ST_RUN && out_fault && !int_fault |=>
         lockout_r && code_r == CODE_OUTPUT;
   endproperty
   a_out_fault: assert property (p_out_fault)
      else $error("output fault missed");

   property p_pwrup_rst;
      @(posedge mclk) disable iff (!rst_b)
      state_r == ST_PWRUP && reset_in && !IS_EMITTER |=>
         lockout_r && disp_data_r == CODE_RESET;
   endproperty
   a_pwrup_rst: assert property (p_pwrup_rst)
      else $error("reset input at power-up not caught");

   property p_int_fault;
      @(posedge mclk) disable iff (!rst_b)
      int_fault |=> !safety_switch_output1_r && !safety_switch_output2_r;
   endproperty
   a_int_fault: assert property (p_int_fault)
      else $error("outputs on after internal fault");

   c_run: cover property (@(posedge mclk) disable iff (!rst_b)
      safety_switch_output1_r);
   c_recover: cover property (@(posedge mclk) disable iff (!rst_b)
      state_r == ST_LOCK ##1 state_r == ST_RUN);
   c_adv: cover property (@(posedge mclk) disable iff (!rst_b)
      disp_sel_r == DSEL_ADV_A ##[1:40] disp_sel_r == DSEL_ADV_B);

endmodule : lrc_lockout_ctrl

// File: rtl/lrc_pkg.sv
// Constants and types for the lockout and recovery controller.
// Assumes one 50 MHz clock and a power-up reset on rst_b.
//
// Behaviour
// - A lockout drives both safety switch outputs off or keeps them off.
// - During a lockout the display shows a code naming its cause.
// - Recovery needs the internal fault gone and then one valid reset sequence.
// - The receiver clears a lockout on a reset pulse of 1/4 s to 2 s.
// - Power cycling clears a lockout; latch mode then waits for a reset.
// - The emitter uses the reset input only to show A and B codes when held 5 s, and clears only by power cycle.
// - In a lockout, reset held high 5 s or flip held 5 s shows alternating A and B codes.
// - Flip held 5 s while advanced codes show returns to standard codes.
// - Shorted, cross-shorted or overloaded outputs cause an output lockout.
// - Reset input high at power-up locks out with code 2.
// - A critical internal fault turns the safety outputs off at once.
package lrc_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_KHZ      = 50000;
   localparam int RST_MIN_MS   = 250;
   localparam int RST_MAX_MS   = 2000;
   localparam int HOLD_MS      = 5000;
   localparam int ALT_MS       = 500;
   localparam int RST_MIN_CYC  = RST_MIN_MS * CLK_KHZ;
   localparam int RST_MAX_CYC  = RST_MAX_MS * CLK_KHZ;
   localparam int HOLD_CYC     = HOLD_MS * CLK_KHZ;
   localparam int ALT_CYC      = ALT_MS * CLK_KHZ;
   localparam int CNT_W        = 28;

   // ----------------------------------------------------------------
   // Display codes and selection
   // ----------------------------------------------------------------
   localparam logic [7:0] CODE_NONE   = 8'h00;
   localparam logic [7:0] CODE_OUTPUT = 8'h01;
   localparam logic [7:0] CODE_RESET  = 8'h02;
   localparam logic [1:0] DSEL_STD    = 2'h0;
   localparam logic [1:0] DSEL_ADV_A  = 2'h1;
   localparam logic [1:0] DSEL_ADV_B  = 2'h2;

   // ----------------------------------------------------------------
   // Control states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_PWRUP = 2'b00,
      ST_WAIT  = 2'b01,
      ST_RUN   = 2'b10,
      ST_LOCK  = 2'b11
   } lrc_state_type;

endpackage : lrc_pkg

// File: tb/lrc_lockout_ctrl_test.sv
// Self-checking bench for the lockout controller, receiver and emitter.
// Assumes shortened counts; machine model closes the read-back loop.
`timescale 1ns/1ps
module lrc_lockout_ctrl_test;
   import lrc_pkg::*;
   localparam int RMIN = 4;
   localparam int RMAX = 20;
   localparam int HLD  = 40;
   localparam int ALTC = 8;
   logic       mclk = 1'b0, rst_b = 1'b0, latch_mode = 1'b0;
   logic       run_ok = 1'b1, reset_in = 1'b0, flip_btn = 1'b0;
   logic       int_fault = 1'b0, overload = 1'b0, s1, s2;
   logic [7:0] int_code = 8'h00, adv_a = 8'ha1, adv_b = 8'hb2, data;
   logic [1:0] short_sel = 2'h0, sel, sv;
   logic       o1, o2, lock, e1, e2, elock;
   int         fail_count = 0, n_tests = 0, cyc = 0;

   lrc_machine_model PM (.out1(o1), .out2(o2), .short_sel(short_sel),
      .sense1(s1), .sense2(s2));
   lrc_lockout_ctrl #(.RST_MIN(RMIN), .RST_MAX(RMAX), .HOLD(HLD),
      .ALT(ALTC)) DUT (.mclk(mclk), .rst_b(rst_b),
      .latch_mode(latch_mode), .run_ok(run_ok), .reset_in(reset_in),
      .flip_btn(flip_btn), .int_fault(int_fault), .int_code(int_code),
      .ssw1_sense(s1), .ssw2_sense(s2), .overload(overload),
      .adv_code_a(adv_a), .adv_code_b(adv_b),
      .safety_switch_output1_r(o1), .safety_switch_output2_r(o2),
      .lockout_r(lock), .disp_sel_r(sel), .disp_data_r(data));
   lrc_lockout_ctrl #(.IS_EMITTER(1'b1), .RST_MIN(RMIN), .RST_MAX(RMAX),
      .HOLD(HLD), .ALT(ALTC)) DUT_E (.mclk(mclk), .rst_b(rst_b),
      .latch_mode(latch_mode), .run_ok(run_ok), .reset_in(reset_in),
      .flip_btn(flip_btn), .int_fault(int_fault), .int_code(int_code),
      .ssw1_sense(1'b0), .ssw2_sense(1'b0), .overload(1'b0),
      .adv_code_a(adv_a), .adv_code_b(adv_b),
      .safety_switch_output1_r(e1), .safety_switch_output2_r(e2),
      .lockout_r(elock), .disp_sel_r(), .disp_data_r());

   initial forever #10 mclk = ~mclk;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                      input string what);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %0t %s", $time, what);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      @(negedge mclk);
   endtask : tick

   task automatic power(input logic rin, input logic lm);
      @(posedge mclk);
      rst_b <= 1'b0;
      reset_in <= rin;
      latch_mode <= lm;
      repeat (4) @(posedge mclk);
      rst_b <= 1'b1;
      tick(4);
   endtask : power

   // operator holds the switch n cycles
   task automatic pulse(input int n);
      @(posedge mclk);
      reset_in <= 1'b1;
      repeat (n) @(posedge mclk);
      reset_in <= 1'b0;
      tick(3);
   endtask : pulse

   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : finish_test

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_pwr_reset;
      power(1'b1, 1'b0);
      chk({7'h0, lock}, 8'h01, "no reset-input lockout");
      chk(data, CODE_RESET, "reset code");
      chk({6'h0, o1, o2}, 8'h00, "outputs on in lockout");
      chk({5'h0, elock, e1, e2}, 8'h00, "emitter used reset");
      tick(18);
      @(posedge mclk);
      reset_in <= 1'b0;
      tick(3);
      chk({7'h0, lock}, 8'h01, "long pulse cleared");
      pulse(RMIN - 2);
      chk({7'h0, lock}, 8'h01, "short pulse cleared");
      pulse(RMIN);
      chk({5'h0, lock, o1, o2}, 8'h03, "min pulse failed");
      chk(data, CODE_NONE, "display not cleared");
      $display("test power-up reset done");
   endtask : t_pwr_reset

   task automatic t_out_fault;
      for (int m = 1; m <= 4; m++) begin
         @(posedge mclk);
         run_ok <= (m != 3);
         short_sel <= (m == 4) ? 2'h0 : m[1:0];
         overload <= (m == 4);
         tick(3);
         chk({5'h0, lock, o1, o2}, 8'h04, "output fault missed");
         chk(data, CODE_OUTPUT, "output code");
         @(posedge mclk);
         short_sel <= 2'h0;
         overload <= 1'b0;
         run_ok <= 1'b1;
         pulse(RMAX);
         chk({5'h0, lock, o1, o2}, 8'h03, "max pulse failed");
      end
      $display("test output faults done");
   endtask : t_out_fault

   task automatic t_int_fault;
      @(posedge mclk);
      int_code <= 8'h5a;
      int_fault <= 1'b1;
      tick(2);
      chk({5'h0, lock, o1, o2}, 8'h04, "internal fault");
      chk(data, 8'h5a, "internal code");
      chk({7'h0, elock}, 8'h01, "emitter fault");
      pulse(RMIN);
      chk({7'h0, lock}, 8'h01, "cleared with fault");
      @(posedge mclk);
      int_fault <= 1'b0;
      pulse(RMIN);
      chk({7'h0, lock}, 8'h00, "no recovery");
      chk({7'h0, elock}, 8'h01, "emitter reset by pulse");
      $display("test internal fault done");
   endtask : t_int_fault

   task automatic t_adv;
      @(posedge mclk);
      int_fault <= 1'b1;
      flip_btn <= 1'b1;
      tick(HLD + 3);
      sv = sel;
      chk({7'h0, sv == DSEL_STD}, 8'h00, "no advanced view");
      chk(data, (sv == DSEL_ADV_A) ? adv_a : adv_b, "adv data");
      tick(ALTC - 1);
      chk({6'h0, sel}, {6'h0, (sv == DSEL_ADV_A) ? DSEL_ADV_B
          : DSEL_ADV_A}, "no alternation");
      @(posedge mclk);
      flip_btn <= 1'b0;
      tick(2);
      @(posedge mclk);
      flip_btn <= 1'b1;
      tick(HLD + 3);
      chk({6'h0, sel}, {6'h0, DSEL_STD}, "no return");
      chk(data, 8'h5a, "standard code");
      @(posedge mclk);
      flip_btn <= 1'b0;
      reset_in <= 1'b1;
      tick(HLD + 3);
      chk({7'h0, sel == DSEL_STD}, 8'h00, "reset hold view");
      @(posedge mclk);
      reset_in <= 1'b0;
      int_fault <= 1'b0;
      tick(3);
      chk({7'h0, lock}, 8'h01, "hold cleared lockout");
      pulse(RMIN);
      chk({6'h0, lock, sel == DSEL_STD}, 8'h01, "exit view");
      $display("test advanced display done");
   endtask : t_adv

   task automatic t_latch;
      @(posedge mclk);
      overload <= 1'b1;
      tick(2);
      chk({7'h0, lock}, 8'h01, "no lockout before cycle");
      @(posedge mclk);
      overload <= 1'b0;
      power(1'b0, 1'b1);
      chk({5'h0, lock, elock, o1}, 8'h00, "latch power-up");
      tick(10);
      chk({6'h0, o1, o2}, 8'h00, "latch outputs on");
      pulse(RMIN);
      chk({6'h0, o1, o2}, 8'h03, "manual reset ignored");
      $display("test latch power cycle done");
   endtask : t_latch

   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         fail_count++;
         $display("BAD %0t timeout", $time);
         finish_test();
      end
   end

   initial begin
      t_pwr_reset();
      t_out_fault();
      t_int_fault();
      t_adv();
      t_latch();
      finish_test();
   end
endmodule : lrc_lockout_ctrl_test

// File: tb/lrc_machine_model.sv
// Machine-side model: read-back of both safety outputs.
// Assumes short_sel is driven by the bench; 0 means healthy wiring.
`timescale 1ns/1ps
module lrc_machine_model (
   input  wire logic       out1,
   input  wire logic       out2,
   input  wire logic [1:0] short_sel,
   output logic            sense1,
   output logic            sense2
);
   // ----------------------------------------------------------------
   // Read-back lines
   // ----------------------------------------------------------------
   // shorts to ground or supply
   assign sense1 = (short_sel == 2'h1) ? 1'b0 :
                   (short_sel == 2'h3) ? 1'b1 : out1;
   assign sense2 = (short_sel == 2'h2) ? 1'b0 : out2;
endmodule : lrc_machine_model
